/* core/trtd_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - code 1010010010 is the one-word one-cycle load of the timer one high reload register.
// - that load puts the auxiliary register into bits 7..4 of the timer one high reload.
// - that load puts the accumulator into bits 3..0 of the same register in the same cycle.
// - code 1010100111 is the one-word one-cycle copy of timer one low reload into timer one.
// - the copy loads all eight timer one count bits from the low reload, bit for bit.
// - code 1000110001 is the one-word one-cycle load of timer two and its low reload.
// - that load puts the auxiliary register into bits 7..4 of timer two and its low reload.
// - that load puts the accumulator into bits 3..0 of timer two and its low reload.
// - code 1010010100 is the one-word one-cycle load of the timer two high reload register.
// - that load puts the auxiliary register into bits 7..4 of the timer two high reload.
// - that load puts the accumulator into bits 3..0 of the same register in the same cycle.
module trtd_core (
  input  wire  logic                  core_clk,
  input  wire  logic                  rst,
  input  wire  trtd_pkg::trtd_instr_s instr,
  input  wire  logic            [3:0] acc,
  input  wire  logic            [3:0] aux,
  input  wire  logic            [7:0] timer_one_low_reload_reg,
  output logic                  [7:0] timer_one_high_reload_reg,
  output logic                  [7:0] timer_two_high_reload_reg,
  output logic                  [7:0] timer_two_low_reload_reg,
  output trtd_pkg::trtd_tload_s       timer_one_load_r,
  output trtd_pkg::trtd_tload_s       timer_two_load_r,
  output logic                        carry_flag_we,
  output logic                        skip_next,
  output logic                        acc_we,
  output logic                        aux_we,
  output logic                        instr_claimed,
  output logic                  [3:0] op_done_r
);

  // ***************************************************************
  // decode
  // ***************************************************************
  trtd_pkg::trtd_op_e op;
  logic               do_t1_hi;
  logic               do_t1_copy;
  logic               do_t2_lo;
  logic               do_t2_hi;

  trtd_decode u_decode (
    .instr (instr),
    .op    (op)
  );

  assign do_t1_hi      = (op == trtd_pkg::TRTD_OP_T1_HI_RLD);
  assign do_t1_copy    = (op == trtd_pkg::TRTD_OP_T1_COPY);
  assign do_t2_lo      = (op == trtd_pkg::TRTD_OP_T2_AND_LO);
  assign do_t2_hi      = (op == trtd_pkg::TRTD_OP_T2_HI_RLD);
  assign instr_claimed = (op != trtd_pkg::TRTD_OP_NONE);

  // these instructions never write flags, never skip and never write back
  assign carry_flag_we = 1'b0;
  assign skip_next     = 1'b0;
  assign acc_we        = 1'b0;
  assign aux_we        = 1'b0;

  // ***************************************************************
  // reload registers, each written whole in one cycle
  // ***************************************************************
  trtd_reload_reg u_t1_hi (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (do_t1_hi),
    .hi_nib   (aux),
    .lo_nib   (acc),
    .q_r      (timer_one_high_reload_reg)
  );

  trtd_reload_reg u_t2_hi (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (do_t2_hi),
    .hi_nib   (aux),
    .lo_nib   (acc),
    .q_r      (timer_two_high_reload_reg)
  );

  trtd_reload_reg u_t2_lo (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (do_t2_lo),
    .hi_nib   (aux),
    .lo_nib   (acc),
    .q_r      (timer_two_low_reload_reg)
  );

  // ***************************************************************
  // timer one count load
  // ***************************************************************
  // only the copy drives timer one; the high reload load leaves it alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_one_load_r.load  <= 1'b0;
      timer_one_load_r.value <= trtd_pkg::TIMER_VAL_RST;
    end else begin
      timer_one_load_r.load <= do_t1_copy;
      if (do_t1_copy) begin
        timer_one_load_r.value <= timer_one_low_reload_reg;
      end
    end
  end

  // ***************************************************************
  // timer two count load
  // ***************************************************************
  // same nibbles as the low reload, so counter and reload agree the cycle after
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timer_two_load_r.load  <= 1'b0;
      timer_two_load_r.value <= trtd_pkg::TIMER_VAL_RST;
    end else begin
      timer_two_load_r.load <= do_t2_lo;
      if (do_t2_lo) begin
        timer_two_load_r.value <= {aux, acc};
      end
    end
  end

  // ***************************************************************
  // completion flags, one pulse per executed instruction
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_done_r <= trtd_pkg::DONE_RST;
    end else begin
      op_done_r <= {do_t2_hi, do_t2_lo, do_t1_copy, do_t1_hi};
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  a_t1_hi_value: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_hi |=> timer_one_high_reload_reg[7:4] == $past(aux))
    else $error("timer one high reload upper nibble wrong");

  a_t1_hi_low: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_hi |=> timer_one_high_reload_reg[3:0] == $past(acc))
    else $error("timer one high reload lower nibble wrong");

  a_t1_hi_nocount: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_hi |=> !timer_one_load_r.load && !timer_two_load_r.load)
    else $error("high reload load touched a timer count");

  a_t1_copy_load: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_copy |=> timer_one_load_r.load
      && timer_one_load_r.value == $past(timer_one_low_reload_reg))
    else $error("timer one copy wrong");

  a_t2_both_load: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_lo |=> timer_two_load_r.load
      && timer_two_load_r.value == timer_two_low_reload_reg
      && timer_two_low_reload_reg == {$past(aux), $past(acc)})
    else $error("timer two and low reload disagree");

  a_t2_hi_value: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_hi |=> timer_two_high_reload_reg == {$past(aux), $past(acc)}
      && !timer_two_load_r.load)
    else $error("timer two high reload wrong");

  a_t2_lo_hold: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_hi |=> $stable(timer_two_low_reload_reg) && $stable(timer_one_high_reload_reg))
    else $error("wrong reload register written");

  a_done_single: assert property (@(posedge core_clk) disable iff (rst)
    instr_claimed |=> $onehot(op_done_r) ##1 (op_done_r == $past(
      {do_t2_hi, do_t2_lo, do_t1_copy, do_t1_hi})))
    else $error("completion not one cycle");

  a_no_side: assert property (@(posedge core_clk) disable iff (rst)
    instr_claimed |-> !carry_flag_we && !skip_next && !acc_we && !aux_we)
    else $error("side effect on flag or skip");

  a_load_pulse: assert property (@(posedge core_clk) disable iff (rst)
    timer_one_load_r.load |-> op_done_r == 4'h2)
    else $error("timer one load without copy");

  // ***************************************************************
  // decode checks
  // ***************************************************************
  // the decoder has no clock of its own, so its checks sit here on core_clk
  a_decode_onehot: assert property (@(posedge core_clk) disable iff (rst)
    $onehot(op))
    else $error("decoded operation not one-hot");

  a_decode_t1_hi: assert property (@(posedge core_clk) disable iff (rst)
    instr.valid && instr.code == trtd_pkg::OPC_LOAD_T1_HI_RLD |-> do_t1_hi)
    else $error("timer one high reload load not decoded");

  a_decode_t1_copy: assert property (@(posedge core_clk) disable iff (rst)
    instr.valid && instr.code == trtd_pkg::OPC_COPY_T1_LO_RLD |-> do_t1_copy)
    else $error("timer one copy not decoded");

  a_decode_t2_both: assert property (@(posedge core_clk) disable iff (rst)
    instr.valid && instr.code == trtd_pkg::OPC_LOAD_T2_AND_LO |-> do_t2_lo)
    else $error("timer two combined load not decoded");

  a_decode_t2_hi: assert property (@(posedge core_clk) disable iff (rst)
    instr.valid && instr.code == trtd_pkg::OPC_LOAD_T2_HI_RLD |-> do_t2_hi)
    else $error("timer two high reload load not decoded");

  a_refuse_invalid: assert property (@(posedge core_clk) disable iff (rst)
    !instr.valid |-> !instr_claimed)
    else $error("instruction claimed without valid");

  a_claim_exact: assert property (@(posedge core_clk) disable iff (rst)
    instr_claimed |-> (do_t1_hi || do_t1_copy || do_t2_lo || do_t2_hi))
    else $error("claim without a decoded operation");

  // ***************************************************************
  // per-instruction effects
  // ***************************************************************
  // each instruction must leave every target it does not name untouched
  a_t1_hi_others: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_hi |=> $stable(timer_two_high_reload_reg) && $stable(timer_two_low_reload_reg))
    else $error("timer one high load wrote a timer two register");

  a_t1_hi_done: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_hi |=> op_done_r == 4'h1)
    else $error("timer one high load not done in one cycle");

  a_t1_hi_whole: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_hi |=> timer_one_high_reload_reg == {$past(aux), $past(acc)})
    else $error("timer one high reload nibbles not written together");

  a_copy_done: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_copy |=> op_done_r == 4'h2)
    else $error("timer one copy not done in one cycle");

  a_copy_regs: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_copy |=> $stable(timer_one_high_reload_reg) && $stable(timer_two_high_reload_reg)
      && $stable(timer_two_low_reload_reg))
    else $error("timer one copy wrote a reload register");

  a_copy_one_timer: assert property (@(posedge core_clk) disable iff (rst)
    do_t1_copy |=> !timer_two_load_r.load)
    else $error("timer one copy loaded timer two");

  a_t1_value_hold: assert property (@(posedge core_clk) disable iff (rst)
    !do_t1_copy |=> $stable(timer_one_load_r.value))
    else $error("timer one load value moved without copy");

  a_t2_lo_done: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_lo |=> op_done_r == 4'h4)
    else $error("timer two combined load not done in one cycle");

  a_t2_lo_upper: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_lo |=> timer_two_low_reload_reg[trtd_pkg::HI_NIB_MSB:trtd_pkg::HI_NIB_LSB]
      == $past(aux)
      && timer_two_load_r.value[trtd_pkg::HI_NIB_MSB:trtd_pkg::HI_NIB_LSB] == $past(aux))
    else $error("timer two upper nibbles wrong");

  a_t2_lo_lower: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_lo |=> timer_two_low_reload_reg[trtd_pkg::LO_NIB_MSB:trtd_pkg::LO_NIB_LSB]
      == $past(acc)
      && timer_two_load_r.value[trtd_pkg::LO_NIB_MSB:trtd_pkg::LO_NIB_LSB] == $past(acc))
    else $error("timer two lower nibbles wrong");

  a_t2_lo_others: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_lo |=> $stable(timer_one_high_reload_reg) && $stable(timer_two_high_reload_reg)
      && !timer_one_load_r.load)
    else $error("timer two combined load touched another target");

  a_t2_value_hold: assert property (@(posedge core_clk) disable iff (rst)
    !do_t2_lo |=> $stable(timer_two_load_r.value))
    else $error("timer two load value moved without its load");

  a_t2_hi_done: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_hi |=> op_done_r == 4'h8)
    else $error("timer two high load not done in one cycle");

  a_t2_hi_upper: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_hi |=> timer_two_high_reload_reg[trtd_pkg::HI_NIB_MSB:trtd_pkg::HI_NIB_LSB]
      == $past(aux))
    else $error("timer two high reload upper nibble wrong");

  a_t2_hi_lower: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_hi |=> timer_two_high_reload_reg[trtd_pkg::LO_NIB_MSB:trtd_pkg::LO_NIB_LSB]
      == $past(acc))
    else $error("timer two high reload lower nibble wrong");

  a_t2_hi_nocount: assert property (@(posedge core_clk) disable iff (rst)
    do_t2_hi |=> !timer_one_load_r.load && !timer_two_load_r.load)
    else $error("timer two high load touched a timer count");

  // ***************************************************************
  // idle cycles and side effects
  // ***************************************************************
  a_idle_regs: assert property (@(posedge core_clk) disable iff (rst)
    !instr_claimed |=> $stable(timer_one_high_reload_reg)
      && $stable(timer_two_high_reload_reg) && $stable(timer_two_low_reload_reg))
    else $error("reload register changed while idle");

  a_idle_loads: assert property (@(posedge core_clk) disable iff (rst)
    !instr_claimed |=> !timer_one_load_r.load && !timer_two_load_r.load)
    else $error("timer load pulse while idle");

  a_idle_done: assert property (@(posedge core_clk) disable iff (rst)
    !instr_claimed |=> op_done_r == trtd_pkg::DONE_RST)
    else $error("completion pulse while idle");

  a_t2_load_pulse: assert property (@(posedge core_clk) disable iff (rst)
    timer_two_load_r.load |-> op_done_r == 4'h4)
    else $error("timer two load without combined load");

  a_never_side: assert property (@(posedge core_clk) disable iff (rst)
    !carry_flag_we && !skip_next && !acc_we && !aux_we)
    else $error("side effect strobe raised");

endmodule : trtd_core

`default_nettype wire

/* common/trtd_pkg.sv */
`default_nettype none

package trtd_pkg;

  // ***************************************************************
  // instruction codes, 10 bits wide
  // ***************************************************************
  localparam int unsigned       CODE_W               = 10;
  localparam logic [9:0]        OPC_LOAD_T1_HI_RLD   = 10'h292;
  localparam logic [9:0]        OPC_COPY_T1_LO_RLD   = 10'h2a7;
  localparam logic [9:0]        OPC_LOAD_T2_AND_LO   = 10'h231;
  localparam logic [9:0]        OPC_LOAD_T2_HI_RLD   = 10'h294;

  // ***************************************************************
  // field layout of an 8-bit timer or reload register
  // ***************************************************************
  localparam int unsigned       NIB_W                = 4;
  localparam int unsigned       BYTE_W               = 8;
  localparam int unsigned       HI_NIB_MSB           = 7;
  localparam int unsigned       HI_NIB_LSB           = 4;
  localparam int unsigned       LO_NIB_MSB           = 3;
  localparam int unsigned       LO_NIB_LSB           = 0;

  // ***************************************************************
  // reset values and timing
  // ***************************************************************
  localparam logic [7:0]        RELOAD_RST           = 8'h00;
  localparam logic [7:0]        TIMER_VAL_RST        = 8'h00;
  localparam logic [3:0]        DONE_RST             = 4'h0;
  localparam int unsigned       EXEC_CYCLES          = 1;
  localparam int unsigned       DONE_W               = 4;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [4:0] {
    TRTD_OP_NONE       = 5'b00001,
    TRTD_OP_T1_HI_RLD  = 5'b00010,
    TRTD_OP_T1_COPY    = 5'b00100,
    TRTD_OP_T2_AND_LO  = 5'b01000,
    TRTD_OP_T2_HI_RLD  = 5'b10000
  } trtd_op_e;

  typedef struct packed {
    logic       valid;
    logic [9:0] code;
  } trtd_instr_s;

  typedef struct packed {
    logic       load;
    logic [7:0] value;
  } trtd_tload_s;

endpackage : trtd_pkg

`default_nettype wire

/* core/trtd_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module trtd_decode (
  input  wire trtd_pkg::trtd_instr_s instr,
  output trtd_pkg::trtd_op_e         op
);

  // ***************************************************************
  // full-width compare; any other code leaves the block idle
  // ***************************************************************
  always_comb begin
    op = trtd_pkg::TRTD_OP_NONE;
    if (instr.valid) begin
      case (instr.code)
        trtd_pkg::OPC_LOAD_T1_HI_RLD: op = trtd_pkg::TRTD_OP_T1_HI_RLD;
        trtd_pkg::OPC_COPY_T1_LO_RLD: op = trtd_pkg::TRTD_OP_T1_COPY;
        trtd_pkg::OPC_LOAD_T2_AND_LO: op = trtd_pkg::TRTD_OP_T2_AND_LO;
        trtd_pkg::OPC_LOAD_T2_HI_RLD: op = trtd_pkg::TRTD_OP_T2_HI_RLD;
        default:                      op = trtd_pkg::TRTD_OP_NONE;
      endcase
    end
  end

endmodule : trtd_decode

`default_nettype wire

/* core/trtd_reload_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module trtd_reload_reg (
  input  wire  logic       core_clk,
  input  wire  logic       rst,
  input  wire  logic       load,
  input  wire  logic [3:0] hi_nib,
  input  wire  logic [3:0] lo_nib,
  output logic       [7:0] q_r
);

  // ***************************************************************
  // nibble-pair register: high nibble and low nibble land together
  // ***************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q_r <= trtd_pkg::RELOAD_RST;
    end else if (load) begin
      q_r[trtd_pkg::HI_NIB_MSB:trtd_pkg::HI_NIB_LSB] <= hi_nib;
      q_r[trtd_pkg::LO_NIB_MSB:trtd_pkg::LO_NIB_LSB] <= lo_nib;
    end
  end

  a_reload_hold: assert property (@(posedge core_clk) disable iff (rst)
    !load |=> $stable(q_r)) else $error("reload register changed without load");

endmodule : trtd_reload_reg

`default_nettype wire

/* sim/trtd_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// timer units and the low reload holder beside the decoder
// ***************************************************************
module trtd_partner (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  lo_wr,
  input  wire logic            [7:0] lo_val,
  input  wire trtd_pkg::trtd_tload_s t1_load,
  input  wire trtd_pkg::trtd_tload_s t2_load,
  output logic                 [7:0] lo_reload_r,
  output logic                 [7:0] t1_cnt_r,
  output logic                 [7:0] t2_cnt_r
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lo_reload_r <= 8'h00;
    end else if (lo_wr) begin
      lo_reload_r <= lo_val;
    end
  end

  // counts run down so that a stray load shows as a jump
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t1_cnt_r <= 8'h00;
      t2_cnt_r <= 8'h00;
    end else begin
      t1_cnt_r <= t1_load.load ? t1_load.value : t1_cnt_r - 8'h01;
      t2_cnt_r <= t2_load.load ? t2_load.value : t2_cnt_r - 8'h01;
    end
  end
endmodule : trtd_partner

`default_nettype wire

/* sim/tb_trtd_core.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_trtd_core;
  logic                  core_clk, rst, lo_wr, carry_we, skip, acc_we, aux_we, claimed;
  trtd_pkg::trtd_instr_s instr;
  trtd_pkg::trtd_tload_s t1_ld, t2_ld;
  logic            [3:0] acc, aux, done;
  logic            [7:0] lo_val, lo_rld, t1h, t2h, t2l, t1_cnt, t2_cnt;
  logic            [7:0] e_low, e_t1h, e_t2h, e_t2l, e_t1v, e_t2v;
  logic           [45:0] expq[$];
  logic           [45:0] rec;
  logic            [9:0] codes[6] = '{trtd_pkg::OPC_LOAD_T1_HI_RLD, trtd_pkg::OPC_COPY_T1_LO_RLD,
    trtd_pkg::OPC_LOAD_T2_AND_LO, trtd_pkg::OPC_LOAD_T2_HI_RLD, 10'h293, 10'h2a6};
  int                    mismatches, tests_run, cycles;

  trtd_core trtd_core_i (.core_clk(core_clk), .rst(rst), .instr(instr), .acc(acc), .aux(aux),
    .timer_one_low_reload_reg(lo_rld), .timer_one_high_reload_reg(t1h),
    .timer_two_high_reload_reg(t2h), .timer_two_low_reload_reg(t2l),
    .timer_one_load_r(t1_ld), .timer_two_load_r(t2_ld), .carry_flag_we(carry_we),
    .skip_next(skip), .acc_we(acc_we), .aux_we(aux_we), .instr_claimed(claimed),
    .op_done_r(done));

  trtd_partner trtd_partner_i (.core_clk(core_clk), .rst(rst), .lo_wr(lo_wr), .lo_val(lo_val),
    .t1_load(t1_ld), .t2_load(t2_ld), .lo_reload_r(lo_rld), .t1_cnt_r(t1_cnt),
    .t2_cnt_r(t2_cnt));

  always #25 core_clk = ~core_clk;

  task automatic results();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ***************************************************************
  // drivers: note the expected result as the request goes out
  // ***************************************************************
  task automatic issue(input logic [9:0] c, input logic v);
    logic [3:0] d;
    logic [7:0] nib;
    logic       l1, l2;
    d = 4'h0;
    l1 = 1'b0;
    l2 = 1'b0;
    @(posedge core_clk);
    #1;
    lo_wr = 1'b0;
    aux = 4'($urandom);
    acc = 4'($urandom);
    instr = '{valid: v, code: c};
    nib = {aux, acc};
    if (v) begin
      case (c)
        trtd_pkg::OPC_LOAD_T1_HI_RLD: begin d = 4'h1; e_t1h = nib; end
        trtd_pkg::OPC_COPY_T1_LO_RLD: begin d = 4'h2; e_t1v = e_low; l1 = 1'b1; end
        trtd_pkg::OPC_LOAD_T2_AND_LO: begin d = 4'h4; e_t2l = nib; e_t2v = nib; l2 = 1'b1; end
        trtd_pkg::OPC_LOAD_T2_HI_RLD: begin d = 4'h8; e_t2h = nib; end
        default: ;
      endcase
    end
    if (d != 4'h0) expq.push_back({d, e_t1h, e_t2h, e_t2l, l1, e_t1v, l2, e_t2v});
    #1;
    `CHK("claimed", d != 4'h0, claimed)
  endtask : issue

  // the design reads the low reload as a level, so it is written a cycle ahead
  task automatic set_low(input logic [7:0] v);
    @(posedge core_clk);
    #1;
    instr.valid = 1'b0;
    lo_wr = 1'b1;
    lo_val = v;
    e_low = v;
  endtask : set_low

  // ***************************************************************
  // monitor: one noted result for every completion pulse
  // ***************************************************************
  always @(posedge core_clk) begin
    #2;
    if (!rst) begin
      `CHK("side effects", 4'h0, {carry_we, skip, acc_we, aux_we})
      if (done !== 4'h0) begin
        if (expq.size() == 0) begin
          `CHK("unexpected op", 4'h0, done)
        end else begin
          rec = expq.pop_front();
          `CHK("result", rec, {done, t1h, t2h, t2l, t1_ld, t2_ld})
        end
      end else begin
        `CHK("idle loads", 2'b00, {t1_ld.load, t2_ld.load})
      end
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 2000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    lo_wr = 1'b0;
    lo_val = 8'h00;
    instr = '0;
    acc = 4'h0;
    aux = 4'h0;
    e_low = 8'h00;
    e_t1h = 8'h00;
    e_t2h = 8'h00;
    e_t2l = 8'h00;
    e_t1v = 8'h00;
    e_t2v = 8'h00;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(49));
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    `CHK("reset regs", {3{trtd_pkg::RELOAD_RST}}, {t1h, t2h, t2l})
    set_low(8'ha5);
    for (int i = 0; i < 6; i++) issue(codes[i], 1'b1);
    for (int i = 0; i < 4; i++) issue(codes[i], 1'b0);
    for (int i = 0; i < 200; i++) begin
      if ($urandom % 8 == 0) set_low(8'($urandom));
      issue(codes[$urandom % 6], ($urandom % 8) != 0);
    end
    issue(10'h000, 1'b0);
    repeat (3) @(posedge core_clk);
    `CHK("missing results", 0, expq.size())
    results();
  end
endmodule : tb_trtd_core

`default_nettype wire
